// ==== rtl/setpoint_sequencer.sv ====
// stored setpoint sequencer: location memory, keypad commit, program modes, triggers
// assumes keypad pulses are one-cycle and come from logic on core_clk_i
//
// What this block does
// - a keyed value is stored only when the commit key follows; otherwise discarded
// - step mode: each run press while idle advances and lights run lamp for hold interval; a press during the hold ends it
// - step mode: run press at last programmed location returns to location 1
// - single pass starts at current location, holds each, then advances
// - single pass ends after last location: lamp off, stays at that location
// - a stored hold interval of zero acts as a reset in every mode
// - continuous mode starts at present location, holds each, then advances
// - continuous mode wraps from last programmed location to location 1 forever
// - second run press in continuous mode stops at the active location
// - choosing single pass or step mode ends continuous cycling
// - duplicate key in location display copies current location into next
// - output key switches setpoint output from the selected location on and off; limit output always follows the selected location
// - power-up and the reset key select location 1
// - only locations 1 to 100 are accepted; others raise the error flag
// - falling edge of external trigger input acts as a run press
// - step, single pass and continuous modes all pulse trigger output after each completed hold
`timescale 1ns/1ps
`default_nettype none
module setpoint_sequencer #(
	parameter int CYC_PER_UNIT = seq_pkg::HOLD_UNIT_CYC
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// keypad entry
	input wire logic entry_key_i,
	input wire seq_pkg::field_e entry_field_i,
	input wire logic [seq_pkg::VAL_W-1:0] entry_val_i,
	input wire logic commit_key_i,
	input wire logic cancel_key_i,
	// keypad commands
	input wire logic run_key_i,
	input wire logic reset_key_i,
	input wire logic copy_key_i,
	input wire logic loc_disp_i,
	input wire logic output_key_i,
	input wire logic mode_key_i,
	input wire seq_pkg::mode_e mode_sel_i,
	// external trigger pins
	input wire logic trig_in_n_i,
	output logic trig_out_n_o,
	// status and output drive
	output logic [seq_pkg::LOC_W-1:0] loc_o,
	output logic run_led_o,
	output logic err_o,
	output logic out_on_o,
	output logic [seq_pkg::SRC_W-1:0] src_o,
	output logic [seq_pkg::LIM_W-1:0] lim_o
);
	import seq_pkg::*;

	typedef enum logic {ST_IDLE, ST_DWELL} state_e;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [SRC_W-1:0] src_mem_ff [LOC_COUNT], nxt_src_mem [LOC_COUNT];
	logic [LIM_W-1:0] lim_mem_ff [LOC_COUNT], nxt_lim_mem [LOC_COUNT];
	logic [HOLD_W-1:0] hold_mem_ff [LOC_COUNT], nxt_hold_mem [LOC_COUNT];
	logic [LOC_W-1:0] last_ff, nxt_last;
	logic [VAL_W-1:0] pend_val_ff, nxt_pend_val;
	field_e pend_fld_ff, nxt_pend_fld;
	logic pend_vld_ff, nxt_pend_vld;
	logic err_ff, nxt_err;
	logic [LOC_W-1:0] loc_ff, nxt_loc;
	state_e state_ff, nxt_state;
	mode_e mode_ff, nxt_mode;
	logic led_ff, nxt_led;
	logic out_on_ff, nxt_out_on;
	logic [SRC_W-1:0] src_ff, nxt_src;
	logic [LIM_W-1:0] lim_ff, nxt_lim;
	logic [TRIG_CNT_W-1:0] trig_cnt_ff, nxt_trig_cnt;
	logic trig_n_ff, nxt_trig_n;
	logic sync1_ff, sync2_ff, sync3_ff;

	logic [LOC_W-1:0] loc_idx, adv_loc, tgt;
	logic run_evt, trig_fall, commit_go, copy_go, entry_ok, tmr_start, tmr_abort, tmr_done, fire;
	logic [HOLD_W-1:0] tmr_units;

	assign loc_idx = loc_ff - 1'b1;
	assign adv_loc = (loc_ff >= last_ff) ? LOC_FIRST : loc_ff + 1'b1;
	assign trig_fall = sync3_ff & ~sync2_ff;
	assign run_evt = run_key_i | trig_fall;
	assign commit_go = commit_key_i & pend_vld_ff;
	assign copy_go = copy_key_i & loc_disp_i & (loc_ff < LOC_LAST);

	// ----------------------------------------
	// trigger input synchroniser
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			sync3_ff <= 1'b1;
		end else begin
			sync1_ff <= trig_in_n_i;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// ----------------------------------------
	// entry range check
	// ----------------------------------------
	always_comb begin
		entry_ok = 1'b0;
		unique case (pend_fld_ff)
			FLD_LOC: entry_ok = (pend_val_ff >= VAL_W'(LOC_FIRST)) && (pend_val_ff <= VAL_W'(LOC_LAST));
			FLD_LIM: entry_ok = (pend_val_ff != '0) && (pend_val_ff <= VAL_W'(LIM_MAX));
			FLD_HOLD: entry_ok = (pend_val_ff == '0) || ((pend_val_ff >= HOLD_MIN) && (pend_val_ff <= HOLD_MAX));
			FLD_SRC: entry_ok = (pend_val_ff >> SRC_W) == '0;
		endcase
	end

	// ----------------------------------------
	// keypad entry and memory
	// ----------------------------------------
	always_comb begin
		nxt_src_mem = src_mem_ff;
		nxt_lim_mem = lim_mem_ff;
		nxt_hold_mem = hold_mem_ff;
		nxt_last = last_ff;
		nxt_pend_val = pend_val_ff;
		nxt_pend_fld = pend_fld_ff;
		nxt_pend_vld = pend_vld_ff;
		nxt_err = err_ff;
		if (entry_key_i) begin
			nxt_pend_val = entry_val_i;
			nxt_pend_fld = entry_field_i;
			nxt_pend_vld = 1'b1;
		end else if (commit_key_i || cancel_key_i) begin
			nxt_pend_vld = 1'b0;
		end
		if (commit_go) begin
			nxt_err = ~entry_ok;
			if (entry_ok && pend_fld_ff != FLD_LOC) begin
				unique case (pend_fld_ff)
					FLD_SRC: nxt_src_mem[loc_idx] = pend_val_ff[SRC_W-1:0];
					FLD_LIM: nxt_lim_mem[loc_idx] = pend_val_ff[LIM_W-1:0];
					FLD_HOLD: nxt_hold_mem[loc_idx] = pend_val_ff[HOLD_W-1:0];
					FLD_LOC: nxt_err = err_ff;
				endcase
				if (loc_ff > last_ff) begin
					nxt_last = loc_ff;
				end
			end
		end else if (copy_go) begin
			nxt_src_mem[loc_ff] = src_mem_ff[loc_idx];
			nxt_lim_mem[loc_ff] = lim_mem_ff[loc_idx];
			nxt_hold_mem[loc_ff] = hold_mem_ff[loc_idx];
			if (loc_ff + 1'b1 > last_ff) begin
				nxt_last = loc_ff + 1'b1;
			end
		end
		if (reset_key_i) begin
			nxt_err = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < LOC_COUNT; i++) begin
				src_mem_ff[i] <= SRC_RST;
				lim_mem_ff[i] <= LIM_RST;
				hold_mem_ff[i] <= HOLD_RST;
			end
			last_ff <= LOC_FIRST;
			pend_val_ff <= '0;
			pend_fld_ff <= FLD_SRC;
			pend_vld_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			src_mem_ff <= nxt_src_mem;
			lim_mem_ff <= nxt_lim_mem;
			hold_mem_ff <= nxt_hold_mem;
			last_ff <= nxt_last;
			pend_val_ff <= nxt_pend_val;
			pend_fld_ff <= nxt_pend_fld;
			pend_vld_ff <= nxt_pend_vld;
			err_ff <= nxt_err;
		end
	end

	// ----------------------------------------
	// program sequencer
	// ----------------------------------------
	hold_timer #(
		.CYC_PER_UNIT(CYC_PER_UNIT)
	) u_hold_timer (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(tmr_start),
		.abort_i(tmr_abort),
		.units_i(tmr_units),
		.done_o(tmr_done)
	);

	always_comb begin
		nxt_loc = loc_ff;
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_led = led_ff;
		tmr_start = 1'b0;
		tmr_units = '0;
		fire = 1'b0;
		tgt = loc_ff;
		if (mode_key_i) begin
			nxt_mode = mode_sel_i;
		end
		unique case (state_ff)
			ST_IDLE: begin
				if (run_evt) begin
					tgt = (mode_ff == MODE_STEP) ? adv_loc : loc_ff;
					nxt_state = ST_DWELL;
				end
			end
			ST_DWELL: begin
				if (run_evt || mode_key_i) begin
					nxt_state = ST_IDLE;
					nxt_led = 1'b0;
				end else if (tmr_done) begin
					fire = 1'b1;
					if (mode_ff == MODE_STEP || (mode_ff == MODE_SINGLE && loc_ff >= last_ff)) begin
						nxt_state = ST_IDLE;
						nxt_led = 1'b0;
					end else begin
						tgt = adv_loc;
					end
				end
			end
		endcase
		if (nxt_state == ST_DWELL && (state_ff == ST_IDLE || tmr_done)) begin
			if (hold_mem_ff[tgt - 1'b1] == '0) begin
				nxt_loc = LOC_FIRST;
				nxt_state = ST_IDLE;
				nxt_led = 1'b0;
			end else begin
				nxt_loc = tgt;
				nxt_led = 1'b1;
				tmr_start = 1'b1;
				tmr_units = hold_mem_ff[tgt - 1'b1];
			end
		end
		if (reset_key_i || (commit_go && entry_ok && pend_fld_ff == FLD_LOC) || copy_go) begin
			nxt_state = ST_IDLE;
			nxt_led = 1'b0;
			tmr_start = 1'b0;
			if (reset_key_i) begin
				nxt_loc = LOC_FIRST;
			end else if (copy_go) begin
				nxt_loc = loc_ff + 1'b1;
			end else begin
				nxt_loc = pend_val_ff[LOC_W-1:0];
			end
		end
	end

	assign tmr_abort = (state_ff == ST_DWELL) && (nxt_state == ST_IDLE) && !fire;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			loc_ff <= LOC_FIRST;
			state_ff <= ST_IDLE;
			mode_ff <= MODE_STEP;
			led_ff <= 1'b0;
		end else begin
			loc_ff <= nxt_loc;
			state_ff <= nxt_state;
			mode_ff <= nxt_mode;
			led_ff <= nxt_led;
		end
	end

	// ----------------------------------------
	// output drive and trigger output
	// ----------------------------------------
	always_comb begin
		nxt_out_on = out_on_ff ^ output_key_i;
		nxt_src = nxt_out_on ? src_mem_ff[nxt_loc - 1'b1] : SRC_RST;
		nxt_lim = lim_mem_ff[nxt_loc - 1'b1];
		nxt_trig_cnt = (trig_cnt_ff != '0) ? trig_cnt_ff - 1'b1 : trig_cnt_ff;
		if (fire) begin
			nxt_trig_cnt = TRIG_CNT_W'(TRIG_PULSE_CYC);
		end
		nxt_trig_n = (nxt_trig_cnt == '0);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_on_ff <= 1'b0;
			src_ff <= SRC_RST;
			lim_ff <= LIM_RST;
			trig_cnt_ff <= '0;
			trig_n_ff <= 1'b1;
		end else begin
			out_on_ff <= nxt_out_on;
			src_ff <= nxt_src;
			lim_ff <= nxt_lim;
			trig_cnt_ff <= nxt_trig_cnt;
			trig_n_ff <= nxt_trig_n;
		end
	end

	assign loc_o = loc_ff;
	assign run_led_o = led_ff;
	assign err_o = err_ff;
	assign out_on_o = out_on_ff;
	assign src_o = src_ff;
	assign lim_o = lim_ff;
	assign trig_out_n_o = trig_n_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	logic quiet;
	assign quiet = !reset_key_i && !commit_key_i && !copy_key_i && !mode_key_i;

	sequence s_dwell_done;
		state_ff == ST_DWELL && tmr_done && !run_evt && quiet;
	endsequence

	a_commit_store: assert property (commit_go && entry_ok && pend_fld_ff == FLD_HOLD
		|=> hold_mem_ff[$past(loc_idx)] == $past(pend_val_ff[HOLD_W-1:0])) else $error("commit lost");
	a_cancel_drop: assert property (cancel_key_i && !entry_key_i |=> !pend_vld_ff) else $error("entry kept");
	a_step_lamp: assert property (state_ff == ST_IDLE && mode_ff == MODE_STEP && run_key_i && quiet
		&& hold_mem_ff[adv_loc - 1'b1] != '0 |=> run_led_o ##1 run_led_o) else $error("lamp off");
	a_step_wrap: assert property (state_ff == ST_IDLE && mode_ff == MODE_STEP && run_evt && quiet
		&& loc_ff >= last_ff |=> loc_ff == LOC_FIRST) else $error("no wrap");
	a_zero_reset: assert property (state_ff == ST_IDLE && run_evt && quiet
		&& hold_mem_ff[tgt - 1'b1] == '0 |=> loc_ff == LOC_FIRST && state_ff == ST_IDLE) else $error("zero hold");
	a_single_end: assert property (s_dwell_done ##0 mode_ff == MODE_SINGLE && loc_ff >= last_ff
		|=> state_ff == ST_IDLE && !run_led_o && $stable(loc_ff)) else $error("single end");
	a_cont_wrap: assert property (s_dwell_done ##0 mode_ff == MODE_CONT && loc_ff >= last_ff
		&& hold_mem_ff[0] != '0 |=> loc_ff == LOC_FIRST && state_ff == ST_DWELL) else $error("cont wrap");
	a_cont_stop: assert property (state_ff == ST_DWELL && run_evt && quiet
		|=> state_ff == ST_IDLE && $stable(loc_ff)) else $error("no stop");
	a_mode_stop: assert property (state_ff == ST_DWELL && mode_key_i && !reset_key_i
		|=> state_ff == ST_IDLE) else $error("mode stop");
	a_copy_step: assert property (copy_go && !reset_key_i && !commit_go
		|=> loc_ff == $past(loc_ff) + 1'b1 && src_mem_ff[loc_idx] == src_mem_ff[loc_idx - 1'b1]) else $error("copy");
	a_reset_loc: assert property (reset_key_i |=> loc_ff == LOC_FIRST) else $error("reset loc");
	a_loc_range: assert property (commit_go && pend_fld_ff == FLD_LOC && pend_val_ff > VAL_W'(LOC_LAST)
		&& !reset_key_i && !copy_key_i |=> err_o && $stable(loc_ff)) else $error("range");
	a_trig_pulse: assert property (s_dwell_done |=> ##1 !trig_out_n_o [*8]) else $error("trig pulse");
	a_trig_start: assert property ($fell(sync2_ff) && state_ff == ST_IDLE && !run_key_i && quiet
		&& hold_mem_ff[tgt - 1'b1] != '0 |=> ##1 run_led_o || state_ff == ST_DWELL) else $error("ext start");
endmodule : setpoint_sequencer
`default_nettype wire

// ==== rtl/seq_pkg.sv ====
// constants and types for the stored setpoint sequencer
// assumes a 100 MHz core clock and hold intervals kept in milliseconds
package seq_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOLD_UNIT_NS = 1000000;
	localparam int HOLD_UNIT_CYC = HOLD_UNIT_NS / CLK_PERIOD_NS;
	localparam int TRIG_PULSE_NS = 10000;
	localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int TRIG_CNT_W = 11;
	localparam int UNIT_CNT_W = 32;

	// ----------------------------------------
	// memory layout and limits
	// ----------------------------------------
	localparam int LOC_W = 7;
	localparam int SRC_W = 16;
	localparam int LIM_W = 8;
	localparam int HOLD_W = 20;
	localparam int VAL_W = 20;
	localparam int LOC_COUNT = 100;
	localparam logic [LOC_W-1:0] LOC_FIRST = 7'h01;
	localparam logic [LOC_W-1:0] LOC_LAST = 7'h64;
	localparam logic [LIM_W-1:0] LIM_MAX = 8'h69;
	localparam logic [HOLD_W-1:0] HOLD_MIN = 20'h00003;
	localparam logic [HOLD_W-1:0] HOLD_MAX = 20'hf41dc;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [SRC_W-1:0] SRC_RST = 16'h0000;
	localparam logic [LIM_W-1:0] LIM_RST = 8'h01;
	localparam logic [HOLD_W-1:0] HOLD_RST = 20'h00003;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {FLD_SRC, FLD_LIM, FLD_HOLD, FLD_LOC} field_e;
	typedef enum logic [1:0] {MODE_STEP, MODE_SINGLE, MODE_CONT} mode_e;
endpackage : seq_pkg

// ==== rtl/hold_timer.sv ====
// hold interval timer counting whole milliseconds
// assumes start and abort are single-cycle pulses from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
	parameter int CYC_PER_UNIT = seq_pkg::HOLD_UNIT_CYC
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [seq_pkg::HOLD_W-1:0] units_i,
	// result
	output logic done_o
);
	import seq_pkg::*;

	logic [HOLD_W-1:0] units_ff, nxt_units;
	logic [UNIT_CNT_W-1:0] cyc_ff, nxt_cyc;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	always_comb begin
		nxt_units = units_ff;
		nxt_cyc = cyc_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (abort_i) begin
			nxt_busy = 1'b0;
		end else if (start_i) begin
			nxt_units = units_i;
			nxt_cyc = UNIT_CNT_W'(CYC_PER_UNIT - 1);
			nxt_busy = (units_i != '0);
		end else if (busy_ff) begin
			if (cyc_ff != '0) begin
				nxt_cyc = cyc_ff - 1'b1;
			end else if (units_ff == HOLD_W'(1)) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end else begin
				nxt_units = units_ff - 1'b1;
				nxt_cyc = UNIT_CNT_W'(CYC_PER_UNIT - 1);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			units_ff <= '0;
			cyc_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			units_ff <= nxt_units;
			cyc_ff <= nxt_cyc;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;
endmodule : hold_timer
`default_nettype wire

// ==== tb/trig_partner.sv ====
// external trigger instrument facing the sequencer pins
// assumes fire_i is a one-cycle pulse on core_clk_i
`timescale 1ns/1ps
`default_nettype none
module trig_partner #(
	parameter int LOW_CYC = 1000
) (
	// clock
	input wire logic core_clk_i,
	// bench command
	input wire logic fire_i,
	// trigger pins
	input wire logic trig_out_n_i,
	output logic trig_in_n_o,
	// observed output pulses
	output logic [7:0] edges_o
);
	int left = 0;
	logic out_q = 1'b1;
	logic [7:0] edge_cnt = 8'h00;

	// ----------------------------------------
	// low pulse, released line pulled high
	// ----------------------------------------
	assign trig_in_n_o = (left == 0);
	assign edges_o = edge_cnt;
	always @(posedge core_clk_i) begin
		if (fire_i) begin
			left <= LOW_CYC;
		end else if (left > 0) begin
			left <= left - 1;
		end
		out_q <= trig_out_n_i;
		if (out_q && !trig_out_n_i) begin
			edge_cnt <= edge_cnt + 8'h01;
		end
	end
endmodule : trig_partner
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the setpoint sequencer
// assumes one 100 MHz clock and the trigger partner model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import seq_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic entry_key = 1'b0, commit_key = 1'b0, cancel_key = 1'b0, run_key = 1'b0;
	logic reset_key = 1'b0, copy_key = 1'b0, loc_disp = 1'b0, output_key = 1'b0, mode_key = 1'b0;
	logic fire = 1'b0;
	logic [VAL_W-1:0] entry_val = 20'h00000;
	field_e fld = FLD_SRC;
	mode_e md = MODE_STEP;
	logic trig_in_n, trig_out_n, run_led, err, out_on;
	logic [LOC_W-1:0] loc;
	logic [SRC_W-1:0] src;
	logic [LIM_W-1:0] lim;
	logic [7:0] edges;
	int errors = 0;
	int num_checks = 0;

	always #5 core_clk_i = ~core_clk_i;

	setpoint_sequencer #(.CYC_PER_UNIT(4)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.entry_key_i(entry_key), .entry_field_i(fld), .entry_val_i(entry_val), .commit_key_i(commit_key),
		.cancel_key_i(cancel_key), .run_key_i(run_key), .reset_key_i(reset_key), .copy_key_i(copy_key),
		.loc_disp_i(loc_disp), .output_key_i(output_key), .mode_key_i(mode_key), .mode_sel_i(md),
		.trig_in_n_i(trig_in_n), .trig_out_n_o(trig_out_n), .loc_o(loc), .run_led_o(run_led),
		.err_o(err), .out_on_o(out_on), .src_o(src), .lim_o(lim));
	trig_partner #(.LOW_CYC(1000)) partner (.core_clk_i(core_clk_i), .fire_i(fire),
		.trig_out_n_i(trig_out_n), .trig_in_n_o(trig_in_n), .edges_o(edges));

	// ----------------------------------------
	// compare and drive helpers
	// ----------------------------------------
	task automatic fail(input string m);
		errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic chk_bit(input logic got, input logic exp, input string m);
		num_checks++;
		if (got !== exp) fail(m);
	endtask : chk_bit
	task automatic chk_loc(input logic [LOC_W-1:0] exp, input string m);
		num_checks++;
		if (loc !== exp) fail(m);
	endtask : chk_loc
	task automatic chk_val(input logic [SRC_W-1:0] got, input logic [SRC_W-1:0] exp, input string m);
		num_checks++;
		if (got !== exp) fail(m);
	endtask : chk_val
	task automatic tap(input int k);
		@(negedge core_clk_i);
		case (k)
			0: commit_key = 1'b1;
			1: cancel_key = 1'b1;
			2: run_key = 1'b1;
			3: reset_key = 1'b1;
			4: copy_key = 1'b1;
			5: output_key = 1'b1;
			default: mode_key = 1'b1;
		endcase
		@(negedge core_clk_i);
		{commit_key, cancel_key, run_key, reset_key, copy_key, output_key, mode_key} = 7'h00;
		@(negedge core_clk_i);
	endtask : tap
	task automatic enter(input field_e f, input logic [VAL_W-1:0] v);
		@(negedge core_clk_i);
		entry_key = 1'b1;
		fld = f;
		entry_val = v;
		@(negedge core_clk_i);
		entry_key = 1'b0;
	endtask : enter
	task automatic store(input field_e f, input logic [VAL_W-1:0] v);
		enter(f, v);
		tap(0);
	endtask : store
	task automatic set_mode(input mode_e m);
		md = m;
		tap(6);
	endtask : set_mode
	task automatic wait_loc(input logic [LOC_W-1:0] v, input int max, input string m);
		int n;
		n = 0;
		while (loc !== v && n < max) begin
			@(negedge core_clk_i);
			n++;
		end
		chk_loc(v, m);
	endtask : wait_loc
	task automatic wait_led(input logic v, input int max, input string m);
		int n;
		n = 0;
		while (run_led !== v && n < max) begin
			@(negedge core_clk_i);
			n++;
		end
		chk_bit(run_led, v, m);
	endtask : wait_led

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk_loc(7'h01, "reset loc");
		chk_bit(run_led | err | out_on, 1'b0, "reset flags");
		chk_val(src, 16'h0000, "reset src");
		chk_val({8'h00, lim}, 16'h0001, "reset lim");
		chk_bit(trig_out_n, 1'b1, "reset trig");
	endtask : t_reset
	task automatic t_commit;
		store(FLD_LOC, 20'h00003);
		chk_loc(7'h03, "loc commit");
		enter(FLD_LIM, 20'h00007);
		tap(1);
		tap(0);
		chk_val({8'h00, lim}, 16'h0001, "cancelled value stored");
		store(FLD_LIM, 20'h00009);
		chk_val({8'h00, lim}, 16'h0009, "lim commit");
		store(FLD_LOC, 20'h00065);
		chk_bit(err, 1'b1, "loc 101 no error");
		chk_loc(7'h03, "loc 101 taken");
		store(FLD_LOC, 20'h00000);
		chk_bit(err, 1'b1, "loc 0 no error");
		store(FLD_LIM, 20'h0006a);
		chk_val({8'h00, lim}, 16'h0009, "limit 106 stored");
		store(FLD_HOLD, 20'h00002);
		chk_bit(err, 1'b1, "hold 2 no error");
		store(FLD_LOC, 20'h00003);
		chk_bit(err, 1'b0, "error kept");
	endtask : t_commit
	task automatic t_output;
		store(FLD_SRC, 20'h01234);
		chk_val(src, 16'h0000, "src while off");
		tap(5);
		chk_bit(out_on, 1'b1, "output on");
		chk_val(src, 16'h1234, "src driven");
		tap(5);
		chk_val(src, 16'h0000, "src after off");
	endtask : t_output
	task automatic t_copy;
		loc_disp = 1'b1;
		tap(4);
		chk_loc(7'h04, "copy dest");
		chk_val({8'h00, lim}, 16'h0009, "copy lim");
		tap(4);
		chk_loc(7'h05, "second copy");
		tap(5);
		chk_val(src, 16'h1234, "copy src");
		tap(5);
		loc_disp = 1'b0;
		tap(4);
		chk_loc(7'h05, "copy without display");
	endtask : t_copy
	task automatic t_step;
		int n;
		tap(3);
		chk_loc(7'h01, "reset key");
		set_mode(MODE_STEP);
		for (int i = 2; i <= 5; i++) begin
			tap(2);
			chk_loc(LOC_W'(i), "step advance");
			chk_bit(run_led, 1'b1, "step lamp");
			n = 0;
			while (run_led === 1'b1 && n < 40) begin
				@(negedge core_clk_i);
				n++;
			end
			chk_bit(logic'(n >= 9 && n <= 15), 1'b1, "step lamp time");
			chk_bit(trig_out_n, 1'b0, "step trig out");
		end
		tap(2);
		chk_loc(7'h01, "step wrap");
		wait_led(1'b0, 40, "wrap lamp");
	endtask : t_step
	task automatic t_zero;
		store(FLD_LOC, 20'h00002);
		store(FLD_HOLD, 20'h00000);
		store(FLD_LOC, 20'h00001);
		tap(2);
		repeat (3) @(negedge core_clk_i);
		chk_loc(7'h01, "zero hold loc");
		chk_bit(run_led, 1'b0, "zero hold lamp");
		store(FLD_LOC, 20'h00002);
		store(FLD_HOLD, 20'h00003);
	endtask : t_zero
	task automatic t_single;
		logic [7:0] n0;
		store(FLD_LOC, 20'h00005);
		store(FLD_HOLD, 20'h0012c);
		store(FLD_LOC, 20'h00004);
		store(FLD_HOLD, 20'h0012c);
		set_mode(MODE_SINGLE);
		n0 = edges;
		tap(2);
		chk_loc(7'h04, "single start");
		chk_bit(run_led, 1'b1, "single lamp");
		wait_loc(7'h05, 1300, "single advance");
		chk_bit(run_led, 1'b1, "single lamp kept");
		wait_led(1'b0, 1300, "single end lamp");
		repeat (1100) @(negedge core_clk_i);
		chk_loc(7'h05, "single park");
		chk_val({8'h00, edges - n0}, 16'h0002, "single trig count");
	endtask : t_single
	task automatic t_cont;
		store(FLD_LOC, 20'h00004);
		set_mode(MODE_CONT);
		tap(2);
		chk_loc(7'h04, "cont start");
		wait_loc(7'h05, 1300, "cont advance");
		wait_loc(7'h01, 1300, "cont wrap");
		wait_loc(7'h04, 100, "cont second lap");
		tap(2);
		chk_bit(run_led, 1'b0, "cont stop lamp");
		repeat (1300) @(negedge core_clk_i);
		chk_loc(7'h04, "cont park");
		tap(2);
		chk_bit(run_led, 1'b1, "cont restart");
		set_mode(MODE_STEP);
		chk_bit(run_led, 1'b0, "mode change stop");
		chk_loc(7'h04, "mode change loc");
	endtask : t_cont
	task automatic t_trig;
		int n;
		store(FLD_LOC, 20'h00001);
		@(negedge core_clk_i);
		fire = 1'b1;
		@(negedge core_clk_i);
		fire = 1'b0;
		wait_loc(7'h02, 10, "trigger input step");
		chk_bit(run_led, 1'b1, "trigger input lamp");
		wait_led(1'b0, 40, "trigger input hold end");
		n = 0;
		while (trig_out_n === 1'b0 && n < 1100) begin
			@(negedge core_clk_i);
			n++;
		end
		chk_bit(logic'(n == TRIG_PULSE_CYC), 1'b1, "trig pulse width");
	endtask : t_trig

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic stop_test;
		if (errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		repeat (2) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		@(negedge core_clk_i);
		t_reset();
		t_commit();
		t_output();
		t_copy();
		t_step();
		t_zero();
		t_single();
		t_cont();
		t_trig();
		stop_test();
	end
	initial begin
		#500000;
		fail("watchdog");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
